/* File: rtl/ibpx_pkg.sv */
package ibpx_pkg;

  localparam int unsigned XLEN        = 32;
  localparam int unsigned FLEN        = 64;
  localparam int unsigned AW          = 8;

  // register offsets
  localparam logic [7:0]  ADDR_PSR      = 8'h00;
  localparam logic [7:0]  ADDR_MODE     = 8'h04;
  localparam logic [7:0]  ADDR_PC       = 8'h08;
  localparam logic [7:0]  ADDR_MERGE_LO = 8'h0C;
  localparam logic [7:0]  ADDR_MERGE_HI = 8'h10;
  localparam logic [7:0]  ADDR_REG_IDX  = 8'h14;
  localparam logic [7:0]  ADDR_IREG     = 8'h18;
  localparam logic [7:0]  ADDR_FREG_LO  = 8'h1C;
  localparam logic [7:0]  ADDR_FREG_HI  = 8'h20;

  // status register fields
  localparam int unsigned PSR_CC      = 0;
  localparam int unsigned PSR_OF      = 1;
  localparam int unsigned PSR_LCC     = 2;
  localparam int unsigned PSR_U       = 3;
  localparam int unsigned PSR_PU      = 4;
  localparam int unsigned PSR_IM      = 5;
  localparam int unsigned PSR_PIM     = 6;
  localparam int unsigned PSR_TRAP_LO = 8;
  localparam int unsigned PSR_TRAP_HI = 11;
  localparam int unsigned PSR_PS_LO   = 12;
  localparam int unsigned PSR_PS_HI   = 13;
  localparam int unsigned PSR_PM_LO   = 16;
  localparam int unsigned PSR_PM_HI   = 23;
  localparam logic [31:0] PSR_MASK    = 32'h00FF_3F7F;
  localparam logic [31:0] PSR_RST     = 32'h0000_0000;

  // mode register fields
  localparam int unsigned MODE_DIM    = 0;
  localparam int unsigned MODE_DS     = 1;
  localparam int unsigned MODE_DUAL   = 2;
  localparam logic [31:0] PC_RST      = 32'h0000_0000;

  localparam logic [31:0] INSTR_STEP  = 32'h0000_0004;
  localparam logic [31:0] LINK_SINGLE = 32'h0000_0004;
  localparam logic [31:0] LINK_DUAL   = 32'h0000_0008;

  // merge field masks and shift amounts per pixel size, plus the depth add mask and shift
  localparam logic [63:0] MASK_PIX8   = 64'hFF00_FF00_FF00_FF00;
  localparam logic [63:0] MASK_PIX16  = 64'hFC00_FC00_FC00_FC00;
  localparam logic [63:0] MASK_PIX32  = 64'hFF00_0000_FF00_0000;
  localparam logic [63:0] MASK_Z      = 64'hFFFF_0000_FFFF_0000;
  localparam logic [5:0]  SH_PIX8     = 6'h08;
  localparam logic [5:0]  SH_PIX16    = 6'h06;
  localparam logic [5:0]  SH_PIX32    = 6'h08;
  localparam logic [5:0]  SH_Z        = 6'h10;

  typedef enum logic [4:0] {
    OP_ADDS, OP_ADDU, OP_SUBS, OP_SUBU,
    OP_AND, OP_ANDH, OP_ANDNOT, OP_ANDNOTH,
    OP_OR, OP_ORH, OP_XOR, OP_XORH,
    OP_BC, OP_BCT, OP_BNC, OP_BNCT,
    OP_BLA, OP_BR, OP_BRI, OP_BTE, OP_BTNE,
    OP_CALL, OP_CALLI, OP_FADDP, OP_FADDZ, OP_NOP
  } ibpx_op_t;

  typedef enum logic [1:0] {
    SEQ_RUN, SEQ_DELAY, SEQ_SKIP
  } ibpx_seq_t;

  typedef struct packed {
    logic       src_dbl;
    logic       res_dbl;
    logic       prec_general;
    logic [7:0] int_bits;
    logic [7:0] fp_bytes;
  } ibpx_dec_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
  } ibpx_bus_t;

endpackage : ibpx_pkg

/* File: rtl/ibpx_exec.sv */
// Overview of operation
// - logic immediates zero-extend, arithmetic/address sign-extend
// - short immediate is five bits zero-extended
// - target is ip plus four plus offset*4
// - decode ss sd dd ds precision suffixes
// - integer sizes 8/16/32, float sizes 32/64/128
// - add flags from carries out of 31/30
// - high forms shift constant; zero result sets flag
// - and-not inverts first source before and
// - plain branch no slot; hinted form one slot
// - failed hinted branch skips next instruction
// - loop add writes sum, flags non-negative, slot
// - direct branch runs one slot then jumps
// - indirect branch restores user and mask on trap
// - trap return picks mode from switch bits
// - indirect target sampled before slot; no alignment trap
// - call links next plus four or eight
// - pixel add sums, shifts and loads merge
// - merge fields and shift follow pixel size
// - depth add shifts merge sixteen, loads halves
// - eight-bit pixel mask, bit zero least significant
// - thirty-two integer and float registers, 5-bit designators
`timescale 1ns/1ps
module ibpx_exec
  import ibpx_pkg::*;
#(
  parameter int unsigned N_IREGS = 32,
  parameter int unsigned N_FREGS = 32
)
(
  input  wire logic              I_MCLK,        // core clock
  input  wire logic              I_RSTN,        // async reset, active low
  input  wire logic              I_INSTR_VALID, // instruction present at O_PC
  input  wire logic [31:0]       I_INSTR,       // instruction word
  output      logic [31:0]       O_PC,          // address of expected instruction
  output      logic              O_DUAL_MODE,   // dual-instruction mode active
  output      ibpx_dec_t         O_DEC,         // suffix decode of last instruction
  input  wire logic [AW-1:0]     I_ADDR,        // register address
  input  wire logic [31:0]       I_WDATA,       // register write data
  input  wire logic              I_WR,          // write strobe
  input  wire logic              I_RD,          // read strobe
  output      logic [31:0]       O_RDATA        // read data, cycle after strobe
);

  generate
    if (N_IREGS != 32 || N_FREGS != 32)
    begin : g_bad_regs
      $error("ibpx_exec supports exactly 32 integer and 32 float registers");
    end
  endgenerate

  logic [31:0]  ireg_mem [N_IREGS];
  logic [63:0]  freg_mem [N_FREGS];
  logic [31:0]  psr_reg;
  logic         dim_reg;
  logic         ds_reg;
  logic         dual_reg;
  logic         mode_pend_reg;
  logic         mode_first_reg;
  logic         mode_two_reg;
  logic         mode_then_reg;
  logic         oneshot_reg;
  logic         oneshot_mode_reg;
  logic [31:0]  pc_reg;
  logic [31:0]  pend_reg;
  ibpx_seq_t    seq_reg;
  logic [63:0]  merge_reg;
  logic [4:0]   idx_reg;
  logic [31:0]  rdata_reg;
  ibpx_dec_t    dec_reg;
  ibpx_bus_t    bus;

  ibpx_op_t     op;
  logic         immf;
  logic [4:0]   s1, s2, d;
  logic [15:0]  imm16;
  logic [31:0]  r1v, r2v, opa, opb, imm_hi, first_source_short_imm, res, ctl_tgt;
  logic [31:0]  lbr_tgt, sbr_tgt, link_addr;
  logic [32:0]  sum33;
  logic         is_sub, c30, of_calc;
  logic [31:0]  bla_sum;
  logic         bla_sign;
  logic [63:0]  fsum, merge_n, mmask;
  logic [5:0]   msh;
  logic         exec_en, ctl_en;
  logic         rf_we, cc_we, cc_n, of_we, of_n, lcc_we;
  logic         fp_we, merge_we, ctl_jump, ctl_delay, ctl_skip, trap_ret;
  logic [4:0]   rf_idx;

  function automatic logic [31:0] read_ireg(input logic [4:0] idx, input logic [31:0] val);
    read_ireg = (idx == 5'h00) ? 32'h0000_0000 : val;
  endfunction : read_ireg

  function automatic logic is_logic_op(input ibpx_op_t o);
    is_logic_op = (o inside {OP_AND, OP_ANDH, OP_ANDNOT, OP_ANDNOTH, OP_OR, OP_ORH, OP_XOR, OP_XORH});
  endfunction : is_logic_op

  // one suffix code serves both the precision and the size views
  function automatic ibpx_dec_t decode_suffix(input logic [1:0] sfx);
    ibpx_dec_t r;
    r = '0;
    r.src_dbl      = sfx[1];
    r.res_dbl      = (sfx == 2'h1) || (sfx == 2'h2);
    r.prec_general = (sfx != 2'h3);
    case (sfx)
      2'h0:    begin r.int_bits = 8'h08; r.fp_bytes = 8'h04; end
      2'h1:    begin r.int_bits = 8'h10; r.fp_bytes = 8'h08; end
      2'h2:    begin r.int_bits = 8'h20; r.fp_bytes = 8'h10; end
      default: begin r.int_bits = 8'h00; r.fp_bytes = 8'h00; end
    endcase
    decode_suffix = r;
  endfunction : decode_suffix

  assign bus.wr    = I_WR;
  assign bus.rd    = I_RD;
  assign bus.addr  = I_ADDR;
  assign bus.wdata = I_WDATA;

  // instruction fields: op, imm flag, src2, dest, src1/imm16
  assign op    = ibpx_op_t'(I_INSTR[31:27]);
  assign immf  = I_INSTR[26];
  assign s2    = I_INSTR[25:21];
  assign d     = I_INSTR[20:16];
  assign s1    = I_INSTR[15:11];
  assign imm16 = I_INSTR[15:0];

  assign r1v = read_ireg(s1, ireg_mem[s1]);
  assign r2v = read_ireg(s2, ireg_mem[s2]);
  // register-only forms ignore the immediate flag entirely
  assign opa = !immf ? r1v :
               is_logic_op(op) ? {16'h0000, imm16} :
               {{16{imm16[15]}}, imm16};
  assign imm_hi = {imm16, 16'h0000};
  assign first_source_short_imm  = immf ? {27'h0, s1} : r1v;

  assign lbr_tgt = pc_reg + INSTR_STEP + {{4{I_INSTR[25]}}, I_INSTR[25:0], 2'b00};
  assign sbr_tgt = pc_reg + INSTR_STEP + {{14{I_INSTR[20]}}, I_INSTR[20:16], I_INSTR[10:0], 2'b00};
  assign link_addr = pc_reg + INSTR_STEP + (dual_reg ? LINK_DUAL : LINK_SINGLE);

  assign is_sub = (op == OP_SUBS) || (op == OP_SUBU);
  assign opb    = is_sub ? ~r2v : r2v;
  assign sum33  = {1'b0, opa} + {1'b0, opb} + {32'h0, is_sub};
  assign c30    = opa[31] ^ opb[31] ^ sum33[31];
  assign of_calc = sum33[32] ^ c30;

  assign bla_sum  = r1v + r2v;
  assign bla_sign = bla_sum[31] ^ ((r1v[31] == r2v[31]) && (bla_sum[31] != r1v[31]));

  assign fsum = freg_mem[s1] + freg_mem[s2];

  always_comb
  begin
    case (psr_reg[PSR_PS_HI:PSR_PS_LO])
      2'h1:    begin mmask = MASK_PIX16; msh = SH_PIX16; end
      2'h2:    begin mmask = MASK_PIX32; msh = SH_PIX32; end
      default: begin mmask = MASK_PIX8;  msh = SH_PIX8;  end
    endcase
    if (op == OP_FADDZ)
    begin
      mmask = MASK_Z;
      msh   = SH_Z;
    end
  end

  assign exec_en = I_INSTR_VALID && (seq_reg != SEQ_SKIP);
  assign ctl_en  = I_INSTR_VALID && (seq_reg == SEQ_RUN);

  always_comb
  begin
    res = 32'h0; rf_we = 1'b0; rf_idx = d;
    cc_we = 1'b0; cc_n = psr_reg[PSR_CC]; of_we = 1'b0; of_n = psr_reg[PSR_OF];
    lcc_we = 1'b0; fp_we = 1'b0; merge_we = 1'b0; merge_n = merge_reg;
    ctl_jump = 1'b0; ctl_delay = 1'b0; ctl_skip = 1'b0; trap_ret = 1'b0;
    ctl_tgt = pc_reg + INSTR_STEP;
    case (op)
      OP_ADDS, OP_SUBS:
      begin
        res = sum33[31:0]; rf_we = 1'b1; cc_we = 1'b1; of_we = 1'b1;
        of_n = of_calc;
        cc_n = sum33[31] ^ of_calc;
      end
      OP_ADDU, OP_SUBU:
      begin
        res = sum33[31:0]; rf_we = 1'b1; cc_we = 1'b1; of_we = 1'b1;
        of_n = sum33[32];
        cc_n = sum33[32];
      end
      OP_AND:     res = opa & r2v;
      OP_ANDH:    res = imm_hi & r2v;
      OP_ANDNOT:  res = ~opa & r2v;
      OP_ANDNOTH: res = ~imm_hi & r2v;
      OP_OR:      res = opa | r2v;
      OP_ORH:     res = imm_hi | r2v;
      OP_XOR:     res = opa ^ r2v;
      OP_XORH:    res = imm_hi ^ r2v;
      OP_BC:      begin ctl_jump = psr_reg[PSR_CC];  ctl_tgt = lbr_tgt; end
      OP_BNC:     begin ctl_jump = !psr_reg[PSR_CC]; ctl_tgt = lbr_tgt; end
      OP_BCT:
      begin
        ctl_delay = psr_reg[PSR_CC];
        ctl_skip  = !psr_reg[PSR_CC];
        ctl_tgt   = lbr_tgt;
      end
      OP_BNCT:
      begin
        ctl_delay = !psr_reg[PSR_CC];
        ctl_skip  = psr_reg[PSR_CC];
        ctl_tgt   = lbr_tgt;
      end
      OP_BLA:
      begin
        res = bla_sum; rf_we = 1'b1; rf_idx = s2; lcc_we = 1'b1;
        ctl_delay = 1'b1;
        ctl_tgt = psr_reg[PSR_LCC] ? sbr_tgt : pc_reg + INSTR_STEP + INSTR_STEP;
      end
      OP_BR:      begin ctl_delay = 1'b1; ctl_tgt = lbr_tgt; end
      OP_BRI:
      begin
        ctl_delay = 1'b1;
        ctl_tgt   = r1v;
        trap_ret  = |psr_reg[PSR_TRAP_HI:PSR_TRAP_LO];
      end
      OP_BTE:     begin ctl_jump = (first_source_short_imm == r2v); ctl_tgt = sbr_tgt; end
      OP_BTNE:    begin ctl_jump = (first_source_short_imm != r2v); ctl_tgt = sbr_tgt; end
      OP_CALL:    begin res = link_addr; rf_we = 1'b1; rf_idx = 5'h01; ctl_delay = 1'b1; ctl_tgt = lbr_tgt; end
      OP_CALLI:   begin res = link_addr; rf_we = 1'b1; rf_idx = 5'h01; ctl_delay = 1'b1; ctl_tgt = r1v; end
      OP_FADDP, OP_FADDZ:
      begin
        fp_we = 1'b1; merge_we = 1'b1;
        merge_n = ((merge_reg >> msh) & ~mmask) | (fsum & mmask);
      end
      default: ;
    endcase
    if (is_logic_op(op))
    begin
      rf_we = 1'b1; cc_we = 1'b1;
      cc_n = (res == 32'h0);
    end
  end

  // register files; bus access through the index register
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      for (int i = 0; i < N_IREGS; i++) ireg_mem[i] <= 32'h0;
      for (int i = 0; i < N_FREGS; i++) freg_mem[i] <= 64'h0;
    end
    else
    begin
      if (exec_en && rf_we && rf_idx != 5'h00)
        ireg_mem[rf_idx] <= res;
      if (exec_en && fp_we)
        freg_mem[d] <= fsum;
      if (bus.wr && bus.addr == ADDR_IREG && idx_reg != 5'h00)
        ireg_mem[idx_reg] <= bus.wdata;
      if (bus.wr && bus.addr == ADDR_FREG_LO)
        freg_mem[idx_reg][31:0] <= bus.wdata;
      if (bus.wr && bus.addr == ADDR_FREG_HI)
        freg_mem[idx_reg][63:32] <= bus.wdata;
    end
  end

  // status: software write lands after the hardware update, so it wins
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      psr_reg <= PSR_RST;
    else
    begin
      if (exec_en && cc_we)
        psr_reg[PSR_CC] <= cc_n;
      if (exec_en && of_we)
        psr_reg[PSR_OF] <= of_n;
      if (ctl_en && lcc_we)
        psr_reg[PSR_LCC] <= !bla_sign;
      if (ctl_en && trap_ret)
      begin
        psr_reg[PSR_U]  <= psr_reg[PSR_PU];
        psr_reg[PSR_IM] <= psr_reg[PSR_PIM];
        psr_reg[PSR_TRAP_HI:PSR_TRAP_LO] <= 4'h0;
      end
      if (bus.wr && bus.addr == ADDR_PSR)
        psr_reg <= bus.wdata & PSR_MASK;
    end
  end

  // sequencing: delay slot and skip
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      pc_reg   <= PC_RST;
      pend_reg <= PC_RST;
      seq_reg  <= SEQ_RUN;
    end
    else if (bus.wr && bus.addr == ADDR_PC)
    begin
      pc_reg  <= bus.wdata;
      seq_reg <= SEQ_RUN;
    end
    else if (I_INSTR_VALID)
    begin
      case (seq_reg)
        SEQ_RUN:
        begin
          if (ctl_jump)
            pc_reg <= ctl_tgt;
          else
            pc_reg <= pc_reg + INSTR_STEP;
          if (ctl_delay)
          begin
            pend_reg <= ctl_tgt;
            seq_reg  <= SEQ_DELAY;
          end
          else if (ctl_skip)
            seq_reg <= SEQ_SKIP;
        end
        // a control transfer sitting in a slot is executed only for its data effects
        SEQ_DELAY:
        begin
          pc_reg  <= pend_reg;
          seq_reg <= SEQ_RUN;
        end
        SEQ_SKIP:
        begin
          pc_reg  <= pc_reg + INSTR_STEP;
          seq_reg <= SEQ_RUN;
        end
        default: seq_reg <= SEQ_RUN;
      endcase
    end
  end

  // instruction mode; a new mode takes effect once the slot retires
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      dim_reg <= 1'b0; ds_reg <= 1'b0; dual_reg <= 1'b0;
      mode_pend_reg <= 1'b0; mode_first_reg <= 1'b0; mode_two_reg <= 1'b0; mode_then_reg <= 1'b0;
      oneshot_reg <= 1'b0; oneshot_mode_reg <= 1'b0;
    end
    else
    begin
      if (ctl_en && trap_ret)
      begin
        mode_pend_reg  <= 1'b1;
        mode_first_reg <= dim_reg;
        mode_two_reg   <= ds_reg;
        mode_then_reg  <= !dim_reg;
      end
      else if (I_INSTR_VALID && seq_reg == SEQ_DELAY && mode_pend_reg)
      begin
        mode_pend_reg <= 1'b0;
        dual_reg      <= mode_first_reg;
        oneshot_reg   <= mode_two_reg;
        oneshot_mode_reg <= mode_then_reg;
      end
      else if (I_INSTR_VALID && oneshot_reg)
      begin
        oneshot_reg <= 1'b0;
        dual_reg    <= oneshot_mode_reg;
      end
      if (bus.wr && bus.addr == ADDR_MODE)
      begin
        dim_reg <= bus.wdata[MODE_DIM];
        ds_reg  <= bus.wdata[MODE_DS];
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      merge_reg <= 64'h0;
    else if (exec_en && merge_we)
      merge_reg <= merge_n;
    else if (bus.wr && bus.addr == ADDR_MERGE_LO)
      merge_reg[31:0] <= bus.wdata;
    else if (bus.wr && bus.addr == ADDR_MERGE_HI)
      merge_reg[63:32] <= bus.wdata;
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      dec_reg <= '0;
    else if (exec_en)
      dec_reg <= decode_suffix(I_INSTR[1:0]);
  end

  // register bus slave; unmapped reads return zero
  always_ff @(posedge I_MCLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      idx_reg   <= 5'h00;
      rdata_reg <= 32'h0;
    end
    else
    begin
      if (bus.wr && bus.addr == ADDR_REG_IDX)
        idx_reg <= bus.wdata[4:0];
      rdata_reg <= 32'h0;
      if (bus.rd)
      begin
        case (bus.addr)
          ADDR_PSR:      rdata_reg <= psr_reg;
          ADDR_MODE:     rdata_reg <= {29'h0, dual_reg, ds_reg, dim_reg};
          ADDR_PC:       rdata_reg <= pc_reg;
          ADDR_MERGE_LO: rdata_reg <= merge_reg[31:0];
          ADDR_MERGE_HI: rdata_reg <= merge_reg[63:32];
          ADDR_REG_IDX:  rdata_reg <= {27'h0, idx_reg};
          ADDR_IREG:     rdata_reg <= read_ireg(idx_reg, ireg_mem[idx_reg]);
          ADDR_FREG_LO:  rdata_reg <= freg_mem[idx_reg][31:0];
          ADDR_FREG_HI:  rdata_reg <= freg_mem[idx_reg][63:32];
          default:       rdata_reg <= 32'h0;
        endcase
      end
    end
  end

  assign O_PC        = pc_reg;
  assign O_DUAL_MODE = dual_reg;
  assign O_DEC       = dec_reg;
  assign O_RDATA     = rdata_reg;

  a_rzero_const: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    ireg_mem[0] == 32'h0) else $error("integer register zero changed");
  a_call_link: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (ctl_en && op == OP_CALL && !(bus.wr && bus.addr == ADDR_IREG)) |=>
    ireg_mem[1] == $past(pc_reg) + ($past(dual_reg) ? 32'h0000_000C : 32'h0000_0008))
    else $error("call link address wrong");
  a_br_delay: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (ctl_en && op == OP_BR && !bus.wr) ##1 (I_INSTR_VALID && !bus.wr) |=>
    pc_reg == $past(pc_reg, 2) + 32'h4 + {$past(I_INSTR[25:0], 2), 2'b00} + {{4{$past(I_INSTR[25], 2)}}, 28'h0})
    else $error("direct branch did not land after one slot");
  a_hint_skip: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (ctl_en && ((op == OP_BCT && !psr_reg[PSR_CC]) || (op == OP_BNCT && psr_reg[PSR_CC])) && !bus.wr)
    ##1 (I_INSTR_VALID && !bus.wr) |=>
    pc_reg == $past(pc_reg, 2) + 32'h8 && $stable(psr_reg[PSR_CC]))
    else $error("failed hinted branch did not skip");
  a_logic_cc: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (exec_en && is_logic_op(op) && !bus.wr) |=> psr_reg[PSR_CC] == ($past(res) == 32'h0))
    else $error("logical zero flag wrong");
  a_adds_of: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (exec_en && op == OP_ADDS && !bus.wr) |=>
    psr_reg[PSR_OF] == ($past(opa[31]) == $past(r2v[31]) && $past(sum33[31]) != $past(opa[31])))
    else $error("signed overflow flag wrong");
  a_addu_flags: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (exec_en && op == OP_ADDU && !bus.wr) |=> psr_reg[PSR_CC] == psr_reg[PSR_OF])
    else $error("unsigned add flags differ");
  a_loop_flag: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (ctl_en && op == OP_BLA && !bus.wr) |=>
    psr_reg[PSR_LCC] == ($signed({$past(r1v[31]), $past(r1v)}) + $signed({$past(r2v[31]), $past(r2v)}) >= 0) &&
    pend_reg == ($past(psr_reg[PSR_LCC]) ? $past(sbr_tgt) : $past(pc_reg) + 32'h8))
    else $error("loop branch flag or target wrong");
  a_zmerge_shift: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (exec_en && op == OP_FADDZ) |=>
    merge_reg[47:32] == $past(merge_reg[63:48]) && merge_reg[63:48] == $past(fsum[63:48]))
    else $error("depth merge shift wrong");

endmodule : ibpx_exec

/* File: sim/ibpx_exec_bench.sv */
`timescale 1ns/1ps
module ibpx_exec_bench;
  import ibpx_pkg::*;
  logic          mclk;
  logic          rstn;
  logic          valid;
  logic [31:0]   instr;
  logic [31:0]   pc;
  logic [AW-1:0] addr;
  logic [31:0]   wdata;
  logic          wr;
  logic          rd;
  logic [31:0]   rdata;
  logic          dual;
  ibpx_dec_t     dec;
  int            err_total;
  int            compares;

  ibpx_exec i_dut (.I_MCLK(mclk), .I_RSTN(rstn), .I_INSTR_VALID(valid), .I_INSTR(instr), .O_PC(pc),
    .O_DUAL_MODE(dual), .O_DEC(dec), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask : bus_wr

  // read data stands only in the cycle after the strobe, so sample right after that edge
  task automatic bus_rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask : bus_rd

  task automatic ireg_rd(input logic [4:0] idx, input logic [31:0] exp);
    bus_wr(ADDR_REG_IDX, {27'h0, idx});
    bus_rd("ireg", ADDR_IREG, exp);
  endtask : ireg_rd

  task automatic exec(input ibpx_op_t op, input logic [26:0] fld);
    @(posedge mclk);
    valid <= 1'b1;
    instr <= {op, fld};
    @(posedge mclk);
    valid <= 1'b0;
    #1;
  endtask : exec

  // back to back pair: the second word is consumed in the cycle right after the first
  task automatic exec2(input ibpx_op_t op1, input logic [26:0] f1, input ibpx_op_t op2, input logic [26:0] f2,
                       input logic [31:0] mid);
    @(posedge mclk);
    valid <= 1'b1;
    instr <= {op1, f1};
    @(posedge mclk);
    instr <= {op2, f2};
    #1;
    chk("pc slot", mid, pc);
    @(posedge mclk);
    valid <= 1'b0;
    #1;
  endtask : exec2

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    #500000;
    err_total++;
    complete_run();
  end

  initial
  begin
    err_total = 0;
    compares  = 0;
    rstn  = 1'b0;
    valid = 1'b0;
    instr = 32'h0;
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    bus_rd("psr", ADDR_PSR, PSR_RST);
    bus_wr(ADDR_PSR, 32'hFFFF_FFFF);
    bus_rd("psr", ADDR_PSR, PSR_MASK);
    bus_wr(ADDR_PSR, 32'h0000_0000);
    bus_rd("unmapped", 8'h3C, 32'h0000_0000);
    bus_wr(ADDR_REG_IDX, 32'h0000_0000);
    bus_wr(ADDR_IREG, 32'hFFFF_FFFF);
    ireg_rd(5'h00, 32'h0000_0000);
    $display("test registers done");
    bus_wr(ADDR_REG_IDX, 32'h0000_0002);
    bus_wr(ADDR_IREG, 32'h0000_0005);
    // 0xFFFF must sign-extend to -1, giving 4 with a carry out of bit 31
    exec(OP_ADDU, {1'b1, 5'h02, 5'h03, 16'hFFFF});
    ireg_rd(5'h03, 32'h0000_0004);
    bus_rd("psr", ADDR_PSR, 32'h0000_0003);
    $display("test add done");
    exec(OP_OR, {1'b1, 5'h00, 5'h04, 16'h8000});
    exec(OP_ANDNOT, {1'b1, 5'h02, 5'h05, 16'h0001});
    bus_rd("psr", ADDR_PSR, 32'h0000_0002);
    exec(OP_ANDH, {1'b1, 5'h02, 5'h06, 16'hFFFF});
    bus_rd("psr", ADDR_PSR, 32'h0000_0003);
    ireg_rd(5'h04, 32'h0000_8000);
    ireg_rd(5'h05, 32'h0000_0004);
    ireg_rd(5'h06, 32'h0000_0000);
    $display("test logic done");
    bus_wr(ADDR_REG_IDX, 32'h0000_0001);
    bus_wr(ADDR_FREG_HI, 32'h1111_2222);
    bus_wr(ADDR_FREG_LO, 32'h3333_4444);
    bus_wr(ADDR_REG_IDX, 32'h0000_0002);
    bus_wr(ADDR_FREG_LO, 32'h0101_0101);
    // suffix .dd: both sources double, result double
    exec(OP_FADDP, {1'b0, 5'h02, 5'h03, 5'h01, 11'h002});
    chk("dec", 32'h0007_2010, {13'h0, dec});
    bus_rd("merge lo", ADDR_MERGE_LO, 32'h3400_4500);
    bus_rd("merge hi", ADDR_MERGE_HI, 32'h1100_2200);
    bus_wr(ADDR_REG_IDX, 32'h0000_0003);
    bus_rd("freg", ADDR_FREG_LO, 32'h3434_4545);
    exec(OP_FADDZ, {1'b0, 5'h02, 5'h03, 5'h01, 11'h002});
    bus_rd("merge hi", ADDR_MERGE_HI, 32'h1111_1100);
    $display("test merge done");
    bus_wr(ADDR_PC, 32'h0000_0100);
    exec2(OP_BR, 27'h000_0003, OP_NOP, 27'h0, 32'h0000_0104);
    chk("pc target", 32'h0000_0110, pc);
    $display("test branch done");
    bus_wr(ADDR_PC, 32'h0000_0200);
    exec2(OP_BNCT, 27'h000_0005, OP_ADDU, {1'b1, 5'h02, 5'h03, 16'h0001}, 32'h0000_0204);
    chk("pc after skip", 32'h0000_0208, pc);
    ireg_rd(5'h03, 32'h0000_0004);
    exec(OP_BC, 27'h000_0001);
    chk("pc bc", 32'h0000_0210, pc);
    exec(OP_BTE, {1'b1, 5'h02, 5'h00, 5'h05, 11'h003});
    chk("pc bte", 32'h0000_0220, pc);
    $display("test skip done");
    bus_wr(ADDR_PC, 32'h0000_0400);
    exec2(OP_BLA, {1'b0, 5'h07, 5'h00, 5'h02, 11'h004}, OP_NOP, 27'h0, 32'h0000_0404);
    chk("pc bla fall", 32'h0000_0408, pc);
    exec2(OP_BLA, {1'b0, 5'h07, 5'h00, 5'h02, 11'h004}, OP_NOP, 27'h0, 32'h0000_040C);
    chk("pc bla jump", 32'h0000_041C, pc);
    ireg_rd(5'h07, 32'h0000_000A);
    $display("test loop done");
    bus_wr(ADDR_PC, 32'h0000_0300);
    exec2(OP_CALL, 27'h000_0002, OP_NOP, 27'h0, 32'h0000_0304);
    chk("pc call", 32'h0000_030C, pc);
    ireg_rd(5'h01, 32'h0000_0308);
    $display("test call done");
    bus_wr(ADDR_REG_IDX, 32'h0000_0008);
    bus_wr(ADDR_IREG, 32'h0000_0500);
    bus_wr(ADDR_MODE, 32'h0000_0001);
    bus_wr(ADDR_PSR, 32'h0000_0150);
    bus_wr(ADDR_PC, 32'h0000_0600);
    // the slot overwrites the target register; the old value must still be used
    exec2(OP_BRI, {1'b0, 5'h00, 5'h00, 5'h08, 11'h000}, OP_OR, {1'b1, 5'h00, 5'h08, 16'h0700}, 32'h0000_0604);
    chk("pc bri", 32'h0000_0500, pc);
    chk("dual", 32'h0000_0001, {31'h0, dual});
    bus_rd("psr", ADDR_PSR, 32'h0000_0078);
    ireg_rd(5'h08, 32'h0000_0700);
    $display("test trap return done");
    complete_run();
  end
endmodule : ibpx_exec_bench
